/* File: hdl/alu_subtract_xor_swap.sv */
// Datapath top: work register, flags and file write-back for four operations
`timescale 1ns/1ps
`default_nettype none
module alu_subtract_xor_swap (
  input wire logic clk,
  input wire logic nrst,
  input wire logic exec,
  input wire alu_pkg::cmd_s cmd,
  input wire logic [alu_pkg::DATA_W-1:0] file_rdata,
  output logic [alu_pkg::ADDR_W-1:0] file_raddr,
  output logic [alu_pkg::DATA_W-1:0] work,
  output var alu_pkg::flags_s flags,
  output logic file_we,
  output logic [alu_pkg::ADDR_W-1:0] file_waddr,
  output logic [alu_pkg::DATA_W-1:0] file_wdata
);
  import alu_pkg::*;

  logic [DATA_W-1:0] result;
  logic c_new;
  logic dc_new;
  logic upd_c;
  logic upd_z;
  logic [DATA_W-1:0] next_work;
  flags_s next_flags;
  logic next_file_we;
  logic [ADDR_W-1:0] next_file_waddr;
  logic [DATA_W-1:0] next_file_wdata;
  logic [ADDR_W-1:0] next_file_raddr;

  // Read address output is registered from the command, one cycle late; the core uses file_rdata in the same cycle
  alu_core u_core (
    .op(cmd.op),
    .work(work),
    .file_val(file_rdata),
    .literal(cmd.literal),
    .result(result),
    .carry(c_new),
    .digit_carry_flag(dc_new),
    .upd_carry(upd_c),
    .upd_zero(upd_z)
  );

  // Literal op ignores the destination bit and always lands in work
  function automatic logic goes_to_file(input cmd_s c);
    return c.op != xor_literal_into_work && c.dest == DEST_FILE;
  endfunction

  always_comb begin
    next_work = work;
    next_flags = flags;
    next_file_we = 1'b0;
    next_file_waddr = file_waddr;
    next_file_wdata = file_wdata;
    next_file_raddr = cmd.file_addr; // RL4
    if (exec) begin
      if (!goes_to_file(cmd)) begin
        next_work = result; // RL2
      end else begin
        next_file_we = 1'b1; // RL2
        next_file_waddr = cmd.file_addr; // RL4
        next_file_wdata = result;
      end
      if (upd_c) begin
        next_flags.carry = c_new; // RL3
        next_flags.digit_carry_flag = dc_new;
      end
      if (upd_z) begin
        next_flags.zero = (result == '0); // RL8
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      work <= WORK_RESET;
      flags <= '0;
      file_we <= 1'b0;
      file_waddr <= '0;
      file_wdata <= '0;
      file_raddr <= '0;
    end else begin
      work <= next_work;
      flags <= next_flags;
      file_we <= next_file_we;
      file_waddr <= next_file_waddr;
      file_wdata <= next_file_wdata;
      file_raddr <= next_file_raddr;
    end
  end

  // Helpers capturing previous-cycle inputs for assertions
  cmd_s pcmd;
  logic pexec;
  logic [DATA_W-1:0] pwork;
  logic [DATA_W-1:0] pfile;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pcmd <= '0;
      pexec <= 1'b0;
      pwork <= '0;
      pfile <= '0;
    end else begin
      pcmd <= cmd;
      pexec <= exec;
      pwork <= work;
      pfile <= file_rdata;
    end
  end

  property p_sub_value;
    @(posedge clk) disable iff (!nrst)
    (pexec && pcmd.op == subtract_work_from_file && pcmd.dest == DEST_WORK)
      |-> work == pfile - pwork;
  endproperty
  a_sub_value: assert property (p_sub_value) else $error("subtract result wrong"); // RL1

  property p_dest_file;
    @(posedge clk) disable iff (!nrst)
    (pexec && goes_to_file(pcmd))
      |-> file_we && file_waddr == pcmd.file_addr && work == pwork;
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination wrong"); // RL2

  property p_sub_carry;
    @(posedge clk) disable iff (!nrst)
    (pexec && pcmd.op == subtract_work_from_file)
      |-> flags.carry == (pwork <= pfile)
        && flags.digit_carry_flag == (pwork[NIB_W-1:0] <= pfile[NIB_W-1:0]);
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong"); // RL3

  property p_raddr;
    @(posedge clk) disable iff (!nrst) file_raddr == $past(cmd.file_addr);
  endproperty
  a_raddr: assert property (p_raddr) else $error("read address not followed"); // RL4

  property p_xorl;
    @(posedge clk) disable iff (!nrst)
    (exec && cmd.op == xor_literal_into_work) |=> work == (pwork ^ pcmd.literal)
      && !file_we && flags.carry == $past(flags.carry);
  endproperty
  a_xorl: assert property (p_xorl) else $error("literal xor wrong"); // RL5

  property p_swap;
    @(posedge clk) disable iff (!nrst)
    (exec && cmd.op == swap_file_nibbles) |=> $stable(flags)
      && (pcmd.dest == DEST_FILE || work == {pfile[NIB_W-1:0], pfile[DATA_W-1:NIB_W]});
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong"); // RL6

  property p_xorf;
    @(posedge clk) disable iff (!nrst)
    (exec && cmd.op == xor_work_with_file && cmd.dest == DEST_FILE)
      |=> file_wdata == (pwork ^ pfile) && flags.digit_carry_flag == $past(flags.digit_carry_flag);
  endproperty
  a_xorf: assert property (p_xorf) else $error("file xor wrong"); // RL7

  property p_zero;
    @(posedge clk) disable iff (!nrst)
    (pexec && pcmd.op != swap_file_nibbles)
      |-> flags.zero == (goes_to_file(pcmd)
        ? (file_wdata == '0) : (work == '0));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // RL8

  property p_sub_file;
    @(posedge clk) disable iff (!nrst)
    (pexec && pcmd.op == subtract_work_from_file && pcmd.dest == DEST_FILE)
      |-> file_wdata == pfile - pwork;
  endproperty
  a_sub_file: assert property (p_sub_file) else $error("subtract write-back wrong"); // RL1

  property p_dest_work;
    @(posedge clk) disable iff (!nrst)
    (pexec && !goes_to_file(pcmd)) |-> !file_we;
  endproperty
  a_dest_work: assert property (p_dest_work) else $error("work op wrote file"); // RL2

  // Idle cycle must not disturb anything the decoder relies on
  property p_idle;
    @(posedge clk) disable iff (!nrst)
    !exec |=> $stable(work) && $stable(flags) && !file_we
      && $stable(file_waddr) && $stable(file_wdata);
  endproperty
  a_idle: assert property (p_idle) else $error("idle cycle changed state"); // RL2

  property p_xorl_dest;
    @(posedge clk) disable iff (!nrst)
    (pexec && pcmd.op == xor_literal_into_work && pcmd.dest == DEST_FILE)
      |-> !file_we && work == (pwork ^ pcmd.literal);
  endproperty
  a_xorl_dest: assert property (p_xorl_dest) else $error("literal xor used dest"); // RL5

  property p_swap_file;
    @(posedge clk) disable iff (!nrst)
    (pexec && pcmd.op == swap_file_nibbles && pcmd.dest == DEST_FILE)
      |-> file_wdata == {pfile[NIB_W-1:0], pfile[DATA_W-1:NIB_W]};
  endproperty
  a_swap_file: assert property (p_swap_file) else $error("swap write-back wrong"); // RL6

  // Carry pair belongs to the last subtract; xors must leave it alone
  property p_xor_keep;
    @(posedge clk) disable iff (!nrst)
    (exec && (cmd.op == xor_literal_into_work || cmd.op == xor_work_with_file))
      |=> $stable(flags.carry) && $stable(flags.digit_carry_flag);
  endproperty
  a_xor_keep: assert property (p_xor_keep) else $error("xor touched carry flags"); // RL7

  property p_xorf_work;
    @(posedge clk) disable iff (!nrst)
    (pexec && pcmd.op == xor_work_with_file && pcmd.dest == DEST_WORK)
      |-> work == (pwork ^ pfile);
  endproperty
  a_xorf_work: assert property (p_xorf_work) else $error("file xor to work wrong"); // RL7

  c_sub: cover property (@(posedge clk) disable iff (!nrst)
    exec && cmd.op == subtract_work_from_file ##1 flags.zero);
  c_swap_file: cover property (@(posedge clk) disable iff (!nrst)
    exec && cmd.op == swap_file_nibbles && cmd.dest == DEST_FILE);
  c_xorl: cover property (@(posedge clk) disable iff (!nrst)
    exec && cmd.op == xor_literal_into_work);
  c_borrow: cover property (@(posedge clk) disable iff (!nrst)
    exec && cmd.op == subtract_work_from_file ##1 !flags.carry);
endmodule
`default_nettype wire

/* File: hdl/alu_pkg.sv */
// Constants and types for the subtract, exclusive-OR and swap datapath
//
// Contract
// RL1: Subtract-from-file computes file minus work, two's complement, eight-bit result.
// RL2: Destination bit 0 writes work register, 1 writes back to file register.
// RL3: Carry set when work not above file; digit carry likewise on low nibbles.
// RL4: File operand is seven-bit address 0..127 with one destination bit.
// RL5: Exclusive-OR literal writes work register and updates only zero flag.
// RL6: Swap exchanges file nibbles and leaves every status flag unchanged.
// RL7: Exclusive-OR file writes selected destination and updates only zero flag.
// RL8: Zero flag set when eight-bit result is zero; subtract updates it too.
package alu_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned NIB_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 7'h7f;
  localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [1:0] {
    subtract_work_from_file = 2'b00,
    xor_literal_into_work = 2'b01,
    swap_file_nibbles = 2'b10,
    xor_work_with_file = 2'b11
  } op_e;

  typedef struct packed {
    op_e op;
    logic [ADDR_W-1:0] file_addr;
    logic dest;
    logic [DATA_W-1:0] literal;
  } cmd_s;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } flags_s;

endpackage

/* File: hdl/alu_core.sv */
// Combinational result and flag computation for the four operations
`timescale 1ns/1ps
`default_nettype none
module alu_core (
  input wire alu_pkg::op_e op,
  input wire logic [alu_pkg::DATA_W-1:0] work,
  input wire logic [alu_pkg::DATA_W-1:0] file_val,
  input wire logic [alu_pkg::DATA_W-1:0] literal,
  output logic [alu_pkg::DATA_W-1:0] result,
  output logic carry,
  output logic digit_carry_flag,
  output logic upd_carry,
  output logic upd_zero
);
  import alu_pkg::*;

  logic [DATA_W:0] diff;
  logic [NIB_W:0] ndiff;

  always_comb begin
    // Ninth bit of f + ~w + 1 is the no-borrow carry
    diff = {1'b0, file_val} + {1'b0, ~work} + {{DATA_W{1'b0}}, 1'b1}; // RL1
    ndiff = {1'b0, file_val[NIB_W-1:0]} + {1'b0, ~work[NIB_W-1:0]}
      + {{NIB_W{1'b0}}, 1'b1};
    result = file_val;
    carry = diff[DATA_W]; // RL3
    digit_carry_flag = ndiff[NIB_W]; // RL3
    upd_carry = 1'b0;
    upd_zero = 1'b0;
    unique case (op)
      subtract_work_from_file: begin
        result = diff[DATA_W-1:0]; // RL1
        upd_carry = 1'b1;
        upd_zero = 1'b1; // RL8
      end
      xor_literal_into_work: begin
        result = work ^ literal; // RL5
        upd_zero = 1'b1;
      end
      swap_file_nibbles: begin
        result = {file_val[NIB_W-1:0], file_val[DATA_W-1:NIB_W]}; // RL6
      end
      xor_work_with_file: begin
        result = work ^ file_val; // RL7
        upd_zero = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: bench/file_memory_model.sv */
// Behavioural data memory answering the datapath's file operand reads
`timescale 1ns/1ps
`default_nettype none
module file_memory_model (
  input wire logic clk,
  input wire logic exec,
  input wire logic [alu_pkg::ADDR_W-1:0] raddr,
  output logic [alu_pkg::DATA_W-1:0] rdata,
  input wire logic we,
  input wire logic [alu_pkg::ADDR_W-1:0] waddr,
  input wire logic [alu_pkg::DATA_W-1:0] wdata
);
  import alu_pkg::*;
  logic [DATA_W-1:0] mem [0:127];
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 37 + 11);
    end
  end
  // Inverse outside an operation, so stale data never passes as valid
  assign rdata = exec ? mem[raddr] : ~mem[raddr];
  // No bypass: a write lands one edge after the pulse
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule
`default_nettype wire

/* File: bench/alu_subtract_xor_swap_tb.sv */
// Self-checking bench for the subtract, exclusive-OR and swap datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module alu_subtract_xor_swap_tb;
  import alu_pkg::*;
  typedef struct packed {
    logic [7:0] w;
    flags_s f;
    logic we;
    logic [6:0] a;
    logic [7:0] d;
  } exp_s;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic exec = 1'b0;
  cmd_s cmd = '0;
  logic [7:0] file_rdata;
  logic [6:0] file_raddr;
  logic [7:0] work;
  flags_s flags;
  logic file_we;
  logic [6:0] file_waddr;
  logic [7:0] file_wdata;
  int n_mismatch = 0;
  int n_checks = 0;
  exp_s q[$];
  exp_s note;
  logic [7:0] shadow [0:127];
  logic [7:0] ew = 8'h00;
  flags_s ef = '0;
  logic took = 1'b0;

  alu_subtract_xor_swap alu_subtract_xor_swap_inst (.clk(clk), .nrst(nrst), .exec(exec),
    .cmd(cmd), .file_rdata(file_rdata), .file_raddr(file_raddr), .work(work),
    .flags(flags), .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata));
  file_memory_model file_memory_model_inst (.clk(clk), .exec(exec), .raddr(cmd.file_addr),
    .rdata(file_rdata), .we(file_we), .waddr(file_waddr), .wdata(file_wdata));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task close_out;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Expectation first, then the request; a file write gets an idle cycle
  task go(input cmd_s c);
    logic [7:0] f;
    logic [7:0] r;
    logic wr;
    f = shadow[c.file_addr];
    wr = (c.dest == DEST_FILE) && (c.op != xor_literal_into_work);
    case (c.op)
      subtract_work_from_file: begin
        r = f - ew;
        ef.carry = (ew <= f);
        ef.digit_carry_flag = (ew[3:0] <= f[3:0]);
      end
      xor_literal_into_work: r = ew ^ c.literal;
      swap_file_nibbles: r = {f[3:0], f[7:4]};
      default: r = ew ^ f;
    endcase
    if (c.op != swap_file_nibbles) begin
      ef.zero = (r == 8'h00);
    end
    if (wr) begin
      shadow[c.file_addr] = r;
    end else begin
      ew = r;
    end
    q.push_back('{ew, ef, wr, c.file_addr, r});
    @(posedge clk);
    exec <= 1'b1;
    cmd <= c;
    if (wr || $urandom_range(0, 3) == 0) begin
      @(posedge clk);
      exec <= 1'b0;
    end
  endtask

  always @(posedge clk) begin
    took <= exec & nrst;
  end

  always @(negedge clk) begin
    if (took) begin
      note = q.pop_front();
      `CHK(work, note.w)
      `CHK(flags, note.f)
      `CHK(file_we, note.we)
      `CHK(file_raddr, note.a)
      if (note.we) begin
        `CHK({file_waddr, file_wdata}, {note.a, note.d})
      end
    end else if (nrst) begin
      `CHK(file_we, 1'b0)
    end
  end

  initial begin
    cmd_s c;
    void'($urandom(32'hf1bcf756));
    for (int i = 0; i < 128; i++) begin
      shadow[i] = 8'(i * 37 + 11);
    end
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    `CHK({work, flags}, {WORK_RESET, 3'b000})
    // Equal operands at the top address, then zero work against the bottom address
    go('{xor_literal_into_work, 7'h00, 1'b1, shadow[127]});
    go('{subtract_work_from_file, 7'h7f, 1'b0, 8'h00});
    go('{subtract_work_from_file, 7'h00, 1'b1, 8'h00});
    go('{swap_file_nibbles, 7'h00, 1'b0, 8'h00});
    go('{xor_work_with_file, 7'h7f, 1'b1, 8'h00});
    for (int i = 0; i < 400; i++) begin
      c = '{op_e'($urandom_range(0, 3)), 7'($urandom), 1'($urandom), 8'($urandom)};
      if ($urandom_range(0, 3) == 0) begin
        c.literal = ew;
      end
      go(c);
    end
    @(posedge clk);
    exec <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(q.size(), 0)
    close_out();
  end

  // Run needs about 630 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
